// >>> tb/tb_top.sv
// Self-checking bench for the power, sequencing and calibration control block.
`timescale 1ns/1ps
module tb_top;
	import tcp_pkg::*;
	localparam int unsigned FP = 20;
	localparam int unsigned LP = 50;
	logic        i_clk, i_rstn, i_irq_req, i_conv_done, i_scl, host_low, ok;
	logic        o_sda, o_sda_oe_n, o_int, o_conv_start, o_cal_allow;
	logic        o_excite_en, o_low_power, o_shutdown;
	logic [1:0]  o_bias_sel;
	logic [3:0]  o_stage_idx;
	logic [4:0]  o_skip_cnt;
	logic [7:0]  o_recal_en;
	logic [8:0]  o_decim;
	logic [15:0] seed, pw, cal, got;
	int          n_errors, tests_run, n;
	logic [15:0] cfg [5] = '{16'h00B0, 16'h00FE, 16'h0016, 16'h000A, 16'h0032};
	int          st [5] = '{12, 12, 2, 1, 4};
	int          gp [5] = '{FP, 4 * LP, 2 * LP, 3 * LP, LP};
	wire         i_sda = host_low ? 1'b0 : (o_sda_oe_n ? 1'b1 : o_sda);
	tcp_top #(.P_FP_CYC(FP), .P_LP_STEP_CYC(LP)) dut_u (
		.i_clk, .i_rstn, .i_scl, .i_sda, .o_sda, .o_sda_oe_n, .i_irq_req, .i_conv_done,
		.o_int, .o_conv_start, .o_stage_idx, .o_cal_allow, .o_recal_en, .o_skip_cnt,
		.o_decim, .o_bias_sel, .o_excite_en, .o_low_power, .o_shutdown
	);
	tcp_host_model host_u (.i_clk, .i_sda_line(i_sda), .o_scl(i_scl), .o_sda_low(host_low));
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic finish_test;
		if (n_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk_outs;
		chk(o_low_power, pw[1:0] == MODE_LOW);
		chk(o_shutdown, pw[0]);
		chk(o_decim, pw[9] ? DECIM_64 : (pw[8] ? DECIM_128 : DECIM_256));
		chk(o_excite_en, !pw[12]);
		chk(o_bias_sel, pw[15:14]);
		chk(o_recal_en, cal[7:0]);
		if (!pw[0])
			chk(o_skip_cnt, pw[1] ? cal[15:14] : (5'h04 << cal[13:12]) - 5'h01);
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		host_u.wr({DEV_ADDR_HI, 2'h3}, {6'h00, a}, d, ok);
		chk(ok, 1'b1);
	endtask
	task automatic rd_chk(input logic [9:0] a, input logic [15:0] e);
		host_u.rd({DEV_ADDR_HI, 2'h1}, {6'h00, a}, got, ok);
		chk(ok, 1'b1);
		chk(got, e);
	endtask
	task automatic wait_start;
		n = 0;
		while (o_conv_start !== 1'b1 && n < 5000) begin
			@(negedge i_clk);
			n++;
		end
	endtask
	// The gap is counted from the cycle after the last stage completes.
	task automatic run_seq(input int s, input int g);
		wait_start;
		for (int i = 0; i < s; i++) begin
			chk(o_stage_idx, i[3:0]);
			chk(o_cal_allow, i < 8 && cal[i]);
			i_conv_done = 1'b1;
			@(negedge i_clk);
			i_conv_done = 1'b0;
			chk(o_conv_start, i < s - 1);
		end
		wait_start;
		chk(n, g);
	endtask
	initial begin
		// A clean run needs roughly two thirds of this span.
		repeat (90000) @(posedge i_clk);
		n_errors++;
		finish_test;
	end
	initial begin
		i_rstn = 1'b0;
		i_irq_req = 1'b0;
		i_conv_done = 1'b0;
		seed = 16'h0046;
		n_errors = 0;
		tests_run = 0;
		pw = 16'h0000;
		cal = 16'h0000;
		repeat (8) @(negedge i_clk);
		i_rstn = 1'b1;
		repeat (3) @(negedge i_clk);
		chk_outs;
		rd_chk(ADDR_POWER_CONFIG, POWER_CONFIG_RST);
		rd_chk(ADDR_STEP_RECAL, STEP_RECAL_RST);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			cal = seed & 16'hF0FF;
			wr(ADDR_STEP_RECAL, cal);
			seed = lfsr(seed);
			pw = (i == 0) ? 16'hFBFF : (i == 1) ? 16'h0400 : seed;
			wr(ADDR_POWER_CONFIG, pw);
			if (pw[SOFT_RESET_BIT]) begin
				pw = 16'h0000;
				cal = 16'h0000;
			end
			pw &= POWER_WR_MASK;
			rd_chk(ADDR_POWER_CONFIG, pw);
			rd_chk(ADDR_STEP_RECAL, cal);
			chk_outs;
		end
		host_u.wr(7'h6C, {6'h00, ADDR_POWER_CONFIG}, 16'h0002, ok);
		chk(ok, 1'b0);
		rd_chk(ADDR_POWER_CONFIG, pw);
		rd_chk(10'h002, 16'h0000);
		i_rstn = 1'b0;
		repeat (2) @(negedge i_clk);
		i_rstn = 1'b1;
		repeat (3) @(negedge i_clk);
		pw = 16'h0000;
		cal = 16'h0000;
		chk_outs;
		rd_chk(ADDR_STEP_RECAL, STEP_RECAL_RST);
		for (int m = 1; m < 4; m += 2) begin
			wr(ADDR_POWER_CONFIG, m[15:0]);
			chk(o_shutdown, 1'b1);
			n = 0;
			repeat (300) begin
				@(negedge i_clk);
				n += o_conv_start;
			end
			chk(n, 0);
		end
		cal = 16'h00A5;
		wr(ADDR_STEP_RECAL, cal);
		for (int k = 0; k < 5; k++) begin
			fork
				wr(ADDR_POWER_CONFIG, cfg[k]);
				run_seq(st[k], gp[k]);
			join
			wr(ADDR_POWER_CONFIG, 16'h0001);
		end
		for (int p = 0; p < 2; p++) begin
			wr(ADDR_POWER_CONFIG, {4'h0, p[0], 11'h001});
			repeat (16) begin
				seed = lfsr(seed);
				i_irq_req = seed[0];
				@(negedge i_clk);
				chk(o_int, p[0] ? seed[0] : !seed[0]);
			end
		end
		finish_test;
	end
endmodule

// >>> tb/tcp_host_model.sv
// Two-wire host model that writes and reads 16-bit registers of the device.
`timescale 1ns/1ps
module tcp_host_model (
	input  wire logic i_clk,
	input  wire logic i_sda_line,
	output logic      o_scl,
	output logic      o_sda_low
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic hp;
		repeat (8) @(negedge i_clk);
	endtask
	// Data is released before the clock rises, so this also serves as a repeated start.
	task automatic start;
		o_sda_low = 1'b0;
		hp;
		o_scl = 1'b1;
		hp;
		o_sda_low = 1'b1;
		hp;
		o_scl = 1'b0;
	endtask
	// Data changes only in mid low phase, well away from either clock edge.
	task automatic xfer(input logic [8:0] w, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			hp;
			o_sda_low = !w[i];
			hp;
			o_scl = 1'b1;
			hp;
			r[i] = i_sda_line;
			o_scl = 1'b0;
		end
	endtask
	task automatic stop;
		hp;
		o_sda_low = 1'b1;
		hp;
		o_scl = 1'b1;
		hp;
		o_sda_low = 1'b0;
		hp;
	endtask
	task automatic wr(input logic [6:0] dev, input logic [15:0] a, input logic [15:0] d,
		output logic ok);
		logic [8:0] r;
		logic [7:0] b [5];
		b = '{{dev, 1'b0}, a[15:8], a[7:0], d[15:8], d[7:0]};
		ok = 1'b1;
		start;
		foreach (b[k]) begin
			xfer({b[k], 1'b1}, r);
			ok &= !r[0];
		end
		stop;
	endtask
	task automatic rd(input logic [6:0] dev, input logic [15:0] a, output logic [15:0] d,
		output logic ok);
		logic [8:0] r;
		logic [7:0] b [4];
		b = '{{dev, 1'b0}, a[15:8], a[7:0], {dev, 1'b1}};
		ok = 1'b1;
		start;
		foreach (b[k]) begin
			if (k == 3)
				start;
			xfer({b[k], 1'b1}, r);
			ok &= !r[0];
		end
		xfer(9'h1FE, r);
		d[15:8] = r[8:1];
		xfer(9'h1FF, r);
		d[7:0] = r[8:1];
		stop;
	endtask
endmodule

// >>> verilog/tcp_i2c_slave.sv
// Serial register port: two-wire slave with 16-bit address and 16-bit data words.
`timescale 1ns/1ps
module tcp_i2c_slave (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda_oe_n,
	output logic             o_wr,
	output logic [9:0]       o_addr,
	output logic [15:0]      o_wdata,
	input  wire logic [15:0] i_rdata
);
	import tcp_pkg::*;

	logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	tcp_i2c_phase_t ph_r, ph_next;
	logic [3:0] cnt_r;
	logic [7:0] sh_r, wd_hi_r, rbyte;
	logic [9:0] addr_r;
	logic       ack_r, drv_r, rd_r, nack_r, wr_r;
	logic [15:0] wdata_r;
	logic start, stop, rise, fall, rd_ph, match;

	assign start = scl_s && scl_d && sda_d && !sda_s;
	assign stop  = scl_s && scl_d && !sda_d && sda_s;
	assign rise  = scl_s && !scl_d;
	assign fall  = !scl_s && scl_d;
	assign rd_ph = (ph_r == P_RHI) || (ph_r == P_RLO);
	assign match = sh_r[7:3] == DEV_ADDR_HI;
	assign rbyte = (ph_next == P_RHI) ? i_rdata[15:8] : i_rdata[7:0];

	always_comb begin
		unique case (ph_r)
			P_DEV:   ph_next = rd_r ? P_RHI : P_AHI;
			P_AHI:   ph_next = P_ALO;
			P_ALO:   ph_next = P_WHI;
			P_WHI:   ph_next = P_WLO;
			P_WLO:   ph_next = P_WHI;
			P_RHI:   ph_next = P_RLO;
			P_RLO:   ph_next = nack_r ? P_IDLE : P_RHI;
			default: ph_next = P_IDLE;
		endcase
	end

	// Both wires are synchronised; the start and stop detectors compare the second stage with the third.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			{scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3F;
		end else begin
			{scl_m, scl_s, scl_d} <= {i_scl, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {i_sda, sda_m, sda_s};
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ph_r <= P_IDLE;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			wd_hi_r <= 8'h00;
			addr_r <= 10'h000;
			{ack_r, drv_r, rd_r, nack_r, wr_r} <= 5'h00;
			wdata_r <= 16'h0000;
		end else begin
			wr_r <= 1'b0;
			if (start) begin
				ph_r <= P_DEV;
				cnt_r <= 4'h0;
				{ack_r, drv_r, nack_r} <= 3'h0;
			end else if (stop) begin
				ph_r <= P_IDLE;
				{ack_r, drv_r} <= 2'h0;
			end else if (ph_r != P_IDLE && rise) begin
				if (ack_r) begin
					nack_r <= sda_s;
				end else begin
					cnt_r <= cnt_r + 4'h1;
					if (!rd_ph) begin
						sh_r <= {sh_r[6:0], sda_s};
					end
				end
			end else if (ph_r != P_IDLE && fall) begin
				if (ack_r) begin
					ack_r <= 1'b0;
					cnt_r <= 4'h0;
					ph_r <= ph_next;
					drv_r <= 1'b0;
					if (ph_next == P_RHI || ph_next == P_RLO) begin
						sh_r <= {rbyte[6:0], 1'b0};
						drv_r <= !rbyte[7];
					end
					if (ph_r == P_WLO) begin
						addr_r <= addr_r + 10'h001;
					end
				end else if (cnt_r == I2C_BITS) begin
					// A foreign device address is left alone until the next start.
					if (ph_r == P_DEV && !match) begin
						ph_r <= P_IDLE;
						drv_r <= 1'b0;
					end else begin
						ack_r <= 1'b1;
						drv_r <= !rd_ph;
						unique case (ph_r)
							P_DEV: rd_r <= sh_r[0];
							P_AHI: addr_r[9:8] <= sh_r[1:0];
							P_ALO: addr_r[7:0] <= sh_r;
							P_WHI: wd_hi_r <= sh_r;
							P_WLO: begin
								wdata_r <= {wd_hi_r, sh_r};
								wr_r <= 1'b1;
							end
							P_RLO: addr_r <= addr_r + 10'h001;
							default: ;
						endcase
					end
				end else if (rd_ph) begin
					drv_r <= !sh_r[7];
					sh_r <= {sh_r[6:0], 1'b0};
				end
			end
		end
	end

	assign o_sda_oe_n = !drv_r;
	assign o_wr       = wr_r;
	assign o_addr     = addr_r;
	assign o_wdata    = wdata_r;
endmodule

// >>> verilog/tcp_pkg.sv
// Shared constants and types for the touch converter power and calibration control block.
package tcp_pkg;
	localparam int unsigned CLK_HZ        = 200_000_000;
	localparam int unsigned FP_PERIOD_MS  = 36;
	localparam int unsigned LP_STEP_MS    = 200;
	localparam int unsigned FP_PERIOD_CYC = FP_PERIOD_MS * (CLK_HZ / 1000);
	localparam int unsigned LP_STEP_CYC   = LP_STEP_MS * (CLK_HZ / 1000);

	localparam logic [9:0]  ADDR_POWER_CONFIG = 10'h000;
	localparam logic [9:0]  ADDR_STEP_RECAL   = 10'h001;
	localparam logic [15:0] POWER_CONFIG_RST  = 16'h0000;
	localparam logic [15:0] STEP_RECAL_RST    = 16'h0000;
	localparam logic [15:0] POWER_WR_MASK     = 16'hDBFF;

	localparam int unsigned SEL_W          = 2;
	localparam int unsigned STAGES_W       = 4;
	localparam int unsigned RECAL_W        = 8;
	localparam int unsigned RECAL_IDX_W    = 3;
	localparam int unsigned MODE_LSB       = 0;
	localparam int unsigned SLEEP_LSB      = 2;
	localparam int unsigned STAGES_LSB     = 4;
	localparam int unsigned DECIM_LSB      = 8;
	localparam int unsigned SOFT_RESET_BIT = 10;
	localparam int unsigned IRQ_POL_BIT    = 11;
	localparam int unsigned EXCITE_OFF_BIT = 12;
	localparam int unsigned UNUSED_BIT     = 13;
	localparam int unsigned BIAS_LSB       = 14;
	localparam int unsigned RECAL_LSB      = 0;
	localparam int unsigned ACT_SKIP_LSB   = 12;
	localparam int unsigned IDLE_SKIP_LSB  = 14;

	localparam logic [1:0] MODE_FULL = 2'h0;
	localparam logic [1:0] MODE_OFF1 = 2'h1;
	localparam logic [1:0] MODE_LOW  = 2'h2;
	localparam logic [1:0] MODE_OFF3 = 2'h3;
	localparam logic [3:0] STAGE_MAX    = 4'hB;
	localparam logic [3:0] RECAL_STAGES = 4'h8;

	localparam logic [1:0] DECIM_CODE_256 = 2'h0;
	localparam logic [1:0] DECIM_CODE_128 = 2'h1;
	localparam logic [8:0] DECIM_256      = 9'h100;
	localparam logic [8:0] DECIM_128      = 9'h080;
	localparam logic [8:0] DECIM_64       = 9'h040;
	localparam logic [4:0] ACT_SKIP_TBL [4] = '{5'h03, 5'h07, 5'h0F, 5'h1F};

	localparam logic [4:0] DEV_ADDR_HI = 5'h0B;
	localparam logic [3:0] I2C_BITS    = 4'h8;

	typedef enum logic [1:0] {S_OFF, S_WAIT, S_CONV} tcp_seq_state_t;
	typedef enum logic [2:0] {P_IDLE, P_DEV, P_AHI, P_ALO, P_WHI, P_WLO, P_RHI, P_RLO}
		tcp_i2c_phase_t;
endpackage

// >>> verilog/tcp_top.sv
// Power, sequencing and calibration control of the touch converter, with its serial register port.
// How it works
// - Mode code 00 runs full power with a sequence about every 36 ms, code 10 runs low power.
// - Mode codes 01 and 11 shut the converter down so that no conversion ever starts.
// - In low power the gap between sequences is 200, 400, 600 or 800 ms by bits 3:2.
// - A sequence has N+1 stages from bits 7:4, at most twelve stages for code 1011 and above.
// - Bits 9:8 select decimation 256, 128, or 64 for both upper codes.
// - Writing one to bit 10 returns both registers to their defaults and the bit never sticks.
// - The interrupt pin is active low when bit 11 is zero and active high when it is one.
// - Bit 12 at zero lets the excitation reach the sense inputs and at one withholds it.
// - Bits 15:14 give the converter bias setting, nominal or plus 20, 35 or 50 percent.
// - Bits 7:0 of the calibration register permit calibration of stages 0 to 7 one by one.
// - In full power averaging skips 3, 7, 15 or 31 samples by bits 13:12.
// - In low power averaging uses all samples or skips 1, 2 or 3 by bits 15:14.
// - Both registers reset to zero, giving full power with all calibration off.
`timescale 1ns/1ps
module tcp_top #(
	parameter int unsigned P_FP_CYC      = tcp_pkg::FP_PERIOD_CYC,
	parameter int unsigned P_LP_STEP_CYC = tcp_pkg::LP_STEP_CYC
) (
	input  wire logic  i_clk,
	input  wire logic  i_rstn,
	input  wire logic  i_scl,
	input  wire logic  i_sda,
	output logic       o_sda,
	output logic       o_sda_oe_n,
	input  wire logic  i_irq_req,
	input  wire logic  i_conv_done,
	output logic       o_int,
	output logic       o_conv_start,
	output logic [3:0] o_stage_idx,
	output logic       o_cal_allow,
	output logic [7:0] o_recal_en,
	output logic [4:0] o_skip_cnt,
	output logic [8:0] o_decim,
	output logic [1:0] o_bias_sel,
	output logic       o_excite_en,
	output logic       o_low_power,
	output logic       o_shutdown
);
	import tcp_pkg::*;

	function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
		return a == r;
	endfunction

	logic [15:0] pwr_r, pwr_nxt, cal_r, cal_nxt, wdata, rdata;
	logic [9:0]  addr;
	logic        wr, soft_rst, pwr_wr, cal_wr;
	logic [1:0]  mode, sleep, decim_code;
	logic [3:0]  stages_n, last_stage, stg_r, stg_nxt;
	logic [7:0]  recal;
	logic        shut, low;
	logic [31:0] cnt_r, cnt_nxt, tgt;
	logic        expire, start_r, start_nxt, int_r;
	tcp_seq_state_t st_r, st_nxt;

	tcp_i2c_slave u_i2c (
		.i_clk      (i_clk),
		.i_rstn     (i_rstn),
		.i_scl      (i_scl),
		.i_sda      (i_sda),
		.o_sda_oe_n (o_sda_oe_n),
		.o_wr       (wr),
		.o_addr     (addr),
		.o_wdata    (wdata),
		.i_rdata    (rdata)
	);

	// Register decode. Software reset wins over the data written beside it.
	assign pwr_wr   = wr && hit(addr, ADDR_POWER_CONFIG);
	assign cal_wr   = wr && hit(addr, ADDR_STEP_RECAL);
	assign soft_rst = pwr_wr && wdata[SOFT_RESET_BIT];
	assign pwr_nxt  = soft_rst ? POWER_CONFIG_RST :
		pwr_wr ? (wdata & POWER_WR_MASK) : pwr_r;
	assign cal_nxt  = soft_rst ? STEP_RECAL_RST : cal_wr ? wdata : cal_r;
	assign rdata    = hit(addr, ADDR_POWER_CONFIG) ? pwr_r :
		hit(addr, ADDR_STEP_RECAL) ? cal_r : 16'h0000;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pwr_r <= POWER_CONFIG_RST;
			cal_r <= STEP_RECAL_RST;
		end else begin
			pwr_r <= pwr_nxt;
			cal_r <= cal_nxt;
		end
	end

	// Field extraction.
	assign mode       = pwr_r[MODE_LSB +: SEL_W];
	assign sleep      = pwr_r[SLEEP_LSB +: SEL_W];
	assign stages_n   = pwr_r[STAGES_LSB +: STAGES_W];
	assign decim_code = pwr_r[DECIM_LSB +: SEL_W];
	assign recal      = cal_r[RECAL_LSB +: RECAL_W];
	assign shut       = (mode == MODE_OFF1) || (mode == MODE_OFF3);
	assign low        = mode == MODE_LOW;
	// Codes above the maximum are clamped rather than running past the last stage bank.
	assign last_stage = (stages_n > STAGE_MAX) ? STAGE_MAX : stages_n;

	// Wait length between sequences; the low power gap is a multiple of the 200 ms step.
	assign tgt    = low ? 32'(P_LP_STEP_CYC * (32'(sleep) + 32'h1)) : 32'(P_FP_CYC);
	// Compare with >= so that shortening the interval mid-wait cannot strand the counter.
	assign expire = (cnt_r + 32'h1) >= tgt;

	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		stg_nxt   = stg_r;
		start_nxt = 1'b0;
		unique case (st_r)
			S_OFF: begin
				if (!shut) begin
					st_nxt  = S_WAIT;
					cnt_nxt = 32'h0;
				end
			end
			S_WAIT: begin
				if (shut) begin
					st_nxt = S_OFF;
				end else if (expire) begin
					st_nxt    = S_CONV;
					stg_nxt   = 4'h0;
					start_nxt = 1'b1;
				end else begin
					cnt_nxt = cnt_r + 32'h1;
				end
			end
			S_CONV: begin
				if (shut) begin
					st_nxt = S_OFF;
				end else if (i_conv_done) begin
					if (stg_r >= last_stage) begin
						st_nxt  = S_WAIT;
						cnt_nxt = 32'h0;
					end else begin
						stg_nxt   = stg_r + 4'h1;
						start_nxt = 1'b1;
					end
				end
			end
			default: st_nxt = S_OFF;
		endcase
		if (soft_rst) begin
			st_nxt    = S_WAIT;
			cnt_nxt   = 32'h0;
			stg_nxt   = 4'h0;
			start_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_r    <= S_WAIT;
			cnt_r   <= 32'h0;
			stg_r   <= 4'h0;
			start_r <= 1'b0;
			int_r   <= 1'b1;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			stg_r   <= stg_nxt;
			start_r <= start_nxt;
			int_r   <= pwr_r[IRQ_POL_BIT] ? i_irq_req : !i_irq_req;
		end
	end

	assign o_sda        = 1'b0;
	assign o_int        = int_r;
	assign o_conv_start = start_r;
	assign o_stage_idx  = stg_r;
	assign o_recal_en   = recal;
	// Stages beyond the eighth have no enable bit, so their calibration is always inhibited.
	assign o_cal_allow  = (st_r == S_CONV) && (stg_r < RECAL_STAGES) &&
		recal[stg_r[RECAL_IDX_W-1:0]];
	assign o_skip_cnt   = low ? {3'h0, cal_r[IDLE_SKIP_LSB +: SEL_W]} :
		ACT_SKIP_TBL[cal_r[ACT_SKIP_LSB +: SEL_W]];
	assign o_decim      = (decim_code == DECIM_CODE_256) ? DECIM_256 :
		(decim_code == DECIM_CODE_128) ? DECIM_128 : DECIM_64;
	assign o_bias_sel   = pwr_r[BIAS_LSB +: SEL_W];
	assign o_excite_en  = !pwr_r[EXCITE_OFF_BIT];
	assign o_low_power  = low;
	assign o_shutdown   = shut;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	// The mode register lands one edge before the sequencer can react, so check the edge after.
	shut_quiet_a: assert property (shut |=> !o_conv_start && st_r != S_CONV)
		else $error("conversion activity during shutdown");
	wait_expiry_a: assert property (o_conv_start && o_stage_idx == 4'h0 |->
		$past(st_r) == S_WAIT && $past(cnt_r) + 32'h1 >= $past(tgt))
		else $error("sequence started before its interval elapsed");
	stage_limit_a: assert property (o_conv_start |-> o_stage_idx <= last_stage)
		else $error("stage index beyond sequence length");
	seq_end_a: assert property (st_r == S_CONV && i_conv_done && stg_r == last_stage
		|=> !o_conv_start && st_r != S_CONV)
		else $error("sequence did not end after last stage");
	decim_map_a: assert property (decim_code >= 2'h2 |-> o_decim == DECIM_64)
		else $error("upper decimation codes must give 64");
	soft_reset_a: assert property (soft_rst |=> pwr_r == POWER_CONFIG_RST &&
		cal_r == STEP_RECAL_RST ##1 !o_conv_start)
		else $error("software reset did not restore defaults");
	irq_pol_a: assert property (1'b1 |=> o_int ==
		($past(pwr_r[IRQ_POL_BIT]) ? $past(i_irq_req) : !$past(i_irq_req)))
		else $error("interrupt pin polarity wrong");
	excite_a: assert property (pwr_wr && !soft_rst |=>
		o_excite_en == !$past(wdata[EXCITE_OFF_BIT]))
		else $error("excitation control does not follow write");
	cal_gate_a: assert property (o_conv_start && o_stage_idx >= RECAL_STAGES |->
		!o_cal_allow)
		else $error("calibration allowed on stage without enable");
	skip_sel_a: assert property (low |-> o_skip_cnt <= 5'h03)
		else $error("low power skip out of range");
	skip_full_a: assert property (!low |-> o_skip_cnt[1:0] == 2'h3)
		else $error("full power skip count not of form 2^k-1");
	sticky_bits_a: assert property (pwr_wr |=> !pwr_r[UNUSED_BIT] &&
		!pwr_r[SOFT_RESET_BIT])
		else $error("unused or self-clearing bit stuck");
endmodule
